// ---- inc/pfc_pkg.sv ----
/*
 Constants shared by the pixel format port converter: register indexes,
 reset values, mode codes, transfer size codes and buffer sizing.
 Assumes a 32-bit APB register bus whose byte address is four times the index.
*/
package pfc_pkg;

   // Register indexes; the byte address on APB is four times the index
   localparam logic [7:0] PFC_IDX_MASK0 = 8'hB8;
   localparam logic [7:0] PFC_IDX_MASK1 = 8'hB9;
   localparam logic [7:0] PFC_IDX_MASK2 = 8'hBA;
   localparam logic [7:0] PFC_IDX_MASK3 = 8'hBB;
   localparam logic [7:0] PFC_IDX_BASE0 = 8'hBC;
   localparam logic [7:0] PFC_IDX_BASE1 = 8'hBD;
   localparam logic [7:0] PFC_IDX_BASE2 = 8'hBE;
   localparam logic [7:0] PFC_IDX_BASE3 = 8'hBF;
   localparam logic [7:0] PFC_IDX_MODE = 8'hC0;
   localparam logic [7:0] PFC_IDX_ARR = 8'hC1;
   localparam logic [7:0] PFC_IDX_STATUS = 8'hC2;
   localparam int PFC_PADDR_W = 10;

   // Values after reset
   localparam logic [31:0] PFC_BASE_RST = 32'h0000_0000;
   localparam logic [27:0] PFC_MASK_RST = 28'h000_0000;
   localparam logic [3:0] PFC_MODE_RST = 4'h0;
   localparam logic [1:0] PFC_ARR_RST = 2'h0;

   // Conversion mode codes
   localparam logic [3:0] PFC_MODE_NONE = 4'h0;
   localparam logic [3:0] PFC_MODE_RGB332 = 4'h1;
   localparam logic [3:0] PFC_MODE_RGB565 = 4'h2;
   localparam logic [3:0] PFC_MODE_LUMINANCE_BYTE = 4'h3;
   localparam logic [3:0] PFC_MODE_ALPHA_BYTE = 4'h5;
   localparam logic [3:0] PFC_MODE_RGBA4444 = 4'h6;
   localparam logic [3:0] PFC_MODE_LUM4A4 = 4'h7;
   localparam logic [3:0] PFC_MODE_LUM8A8 = 4'hA;

   // Byte arrangement codes, channels from the top byte downward
   localparam logic [1:0] PFC_ARR_ARGB = 2'h0;
   localparam logic [1:0] PFC_ARR_RGBA = 2'h1;
   localparam logic [1:0] PFC_ARR_ABGR = 2'h2;
   localparam logic [1:0] PFC_ARR_BGRA = 2'h3;

   // Memory transfer size codes
   localparam logic [1:0] PFC_SIZE_BYTE = 2'h0;
   localparam logic [1:0] PFC_SIZE_HALF = 2'h1;
   localparam logic [1:0] PFC_SIZE_WORD = 2'h2;

   localparam logic [7:0] PFC_ALPHA_OPAQUE = 8'hFF;
   localparam int PFC_FIFO_DEPTH = 32;

   typedef enum logic [1:0] {
      PFC_APB_IDLE = 2'b01,
      PFC_APB_DONE = 2'b10
   } pfc_apb_state_type;

endpackage

// ---- src/pfc_converter.sv ----
/*
 Pixel format port converter: APB register file, address translation,
 ARGB data packing and unpacking, and a request FIFO in front of memory.
 Assumes one clock, a memory that answers reads in order with right
 justified data, and a bus master that issues only 32-bit port accesses.
*/
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module pfc_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam logic [AW:0] FULL_CNT = (AW + 1)'(DEPTH);
   localparam logic [AW-1:0] LAST_IDX = AW'(DEPTH - 1);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] wptr;
      logic [AW-1:0] rptr;
      logic [AW:0] count;
      logic in_ready;
      logic out_valid;
   } pfc_fifo_state_type;

   pfc_fifo_state_type s_r;
   pfc_fifo_state_type s_nxt;
   logic push;
   logic pop;

   assign push = in_valid & s_r.in_ready;
   assign pop = s_r.out_valid & out_ready;
   assign in_ready = s_r.in_ready;
   assign out_valid = s_r.out_valid;
   assign out_data = s_r.mem[s_r.rptr];

   always_comb begin
      s_nxt = s_r;
      if (push) begin
         s_nxt.mem[s_r.wptr] = in_data;
         s_nxt.wptr = (s_r.wptr == LAST_IDX) ? '0 : s_r.wptr + 1'b1;
      end
      if (pop) begin
         s_nxt.rptr = (s_r.rptr == LAST_IDX) ? '0 : s_r.rptr + 1'b1;
      end
      case ({push, pop})
         2'b10: s_nxt.count = s_r.count + 1'b1;
         2'b01: s_nxt.count = s_r.count - 1'b1;
         default: s_nxt.count = s_r.count;
      endcase
      // Flags are registered so the ready and valid ports come from flops
      s_nxt.in_ready = (s_nxt.count != FULL_CNT);
      s_nxt.out_valid = (s_nxt.count != '0);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_r <= '0;
         s_r.in_ready <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end
endmodule

module pfc_converter
   import pfc_pkg::*;
#(
   parameter int FIFO_DEPTH = PFC_FIFO_DEPTH
) (
   input wire logic pclk,
   input wire logic presetn,
   // APB register port
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [PFC_PADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Converter port, driven by the internal bus master
   input wire logic port_valid,
   output logic port_ready,
   input wire logic port_write,
   input wire logic [31:0] port_addr,
   input wire logic [31:0] port_wdata,
   output logic port_rvalid,
   output logic [31:0] port_rdata,
   // Memory side
   output logic mem_valid,
   input wire logic mem_ready,
   output logic mem_write,
   output logic [31:0] mem_addr,
   output logic [31:0] mem_wdata,
   output logic [1:0] mem_size,
   input wire logic mem_rvalid,
   input wire logic [31:0] mem_rdata
);
   localparam int CMD_W = 1 + 32 + 32 + 2;

   typedef struct packed {
      logic [31:0] target_base_address;
      logic [27:0] mask;
      logic [3:0] mode;
      logic [1:0] arr;
      pfc_apb_state_type ast;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
      logic cmd_valid;
      logic cmd_write;
      logic [31:0] cmd_addr;
      logic [31:0] cmd_wdata;
      logic [1:0] cmd_size;
      logic rvalid;
      logic [31:0] rdata;
   } pfc_state_type;

   pfc_state_type s_r;
   pfc_state_type s_nxt;

   logic fifo_in_ready;
   logic fifo_out_valid;
   logic fifo_out_ready;
   logic [CMD_W-1:0] fifo_in_data;
   logic [CMD_W-1:0] fifo_out_data;

   // Unpack a port word into {a, r, g, b} under the chosen arrangement
   function automatic logic [31:0] to_argb(input logic [31:0] w, input logic [1:0] arr);
      logic [31:0] c;
      case (arr)
         PFC_ARR_ARGB: c = w;
         PFC_ARR_RGBA: c = {w[7:0], w[31:24], w[23:16], w[15:8]};
         PFC_ARR_ABGR: c = {w[31:24], w[7:0], w[15:8], w[23:16]};
         PFC_ARR_BGRA: c = {w[7:0], w[15:8], w[23:16], w[31:24]};
         default: c = w;
      endcase
      return c;
   endfunction

   // Place {a, r, g, b} into a port word under the chosen arrangement
   function automatic logic [31:0] from_argb(input logic [31:0] c, input logic [1:0] arr);
      logic [31:0] w;
      case (arr)
         PFC_ARR_ARGB: w = c;
         PFC_ARR_RGBA: w = {c[23:16], c[15:8], c[7:0], c[31:24]};
         PFC_ARR_ABGR: w = {c[31:24], c[7:0], c[15:8], c[23:16]};
         PFC_ARR_BGRA: w = {c[7:0], c[15:8], c[23:16], c[31:24]};
         default: w = c;
      endcase
      return w;
   endfunction

   function automatic logic is_fmt8(input logic [3:0] m);
      return (m == PFC_MODE_RGB332) || (m == PFC_MODE_LUMINANCE_BYTE) ||
         (m == PFC_MODE_ALPHA_BYTE) || (m == PFC_MODE_LUM4A4);
   endfunction

   function automatic logic is_fmt16(input logic [3:0] m);
      return (m == PFC_MODE_RGB565) || (m == PFC_MODE_RGBA4444) ||
         (m == PFC_MODE_LUM8A8);
   endfunction

   // Expand memory data (right justified) into an {a, r, g, b} word
   function automatic logic [31:0] expand(input logic [31:0] d, input logic [3:0] m);
      logic [31:0] c;
      c = d;
      case (m)
         PFC_MODE_RGB332: c = {PFC_ALPHA_OPAQUE, d[7:5], d[7:5], d[7:6], d[4:2], d[4:2],
            d[4:3], d[1:0], d[1:0], d[1:0], d[1:0]};
         PFC_MODE_RGB565: c = {PFC_ALPHA_OPAQUE, d[15:11], d[15:13], d[10:5], d[10:9],
            d[4:0], d[4:2]};
         PFC_MODE_LUMINANCE_BYTE: c = {PFC_ALPHA_OPAQUE, d[7:0], d[7:0], d[7:0]};
         PFC_MODE_ALPHA_BYTE: c = {d[7:0], 24'h00_0000};
         PFC_MODE_RGBA4444: c = {d[3:0], d[3:0], d[15:12], d[15:12], d[11:8], d[11:8],
            d[7:4], d[7:4]};
         PFC_MODE_LUM4A4: c = {d[3:0], d[3:0], {3{d[7:4], d[7:4]}}};
         PFC_MODE_LUM8A8: c = {d[7:0], d[15:8], d[15:8], d[15:8]};
         default: c = d;
      endcase
      return c;
   endfunction

   // Address translation and write packing, done as the request is taken
   logic [27:0] masked_port_offset;
   logic [27:0] scaled_port_offset;
   logic [31:0] memory_target_address;
   logic [31:0] write_argb;
   logic [31:0] write_data;
   logic [1:0] write_size;

   always_comb begin
      masked_port_offset = port_addr[27:0] & ~s_r.mask;
      if (is_fmt8(s_r.mode)) begin
         scaled_port_offset = {2'h0, masked_port_offset[27:2]};
      end else if (is_fmt16(s_r.mode)) begin
         scaled_port_offset = {1'h0, masked_port_offset[27:1]};
      end else begin
         scaled_port_offset = masked_port_offset;
      end
      memory_target_address = s_r.target_base_address + {4'h0, scaled_port_offset};
      write_argb = to_argb(port_wdata, s_r.arr);
      // Read-only formats forward the low bits raw at the pixel size
      write_data = port_wdata;
      write_size = PFC_SIZE_WORD;
      if (is_fmt8(s_r.mode)) begin
         write_size = PFC_SIZE_BYTE;
         write_data = {24'h00_0000, port_wdata[7:0]};
      end else if (is_fmt16(s_r.mode)) begin
         write_size = PFC_SIZE_HALF;
         write_data = {16'h0000, port_wdata[15:0]};
      end
      if (s_r.mode == PFC_MODE_RGB332) begin
         write_data = {24'h00_0000, write_argb[23:21], write_argb[15:13],
            write_argb[7:6]};
      end else if (s_r.mode == PFC_MODE_RGB565) begin
         write_data = {16'h0000, write_argb[23:19], write_argb[15:10],
            write_argb[7:3]};
      end
   end

   // Whole 32-bit port words enter here; narrower masters are not supported
   assign fifo_in_data = {port_write, memory_target_address, write_data, write_size};
   assign fifo_out_ready = ~s_r.cmd_valid | mem_ready;

   pfc_fifo #(
      .WIDTH(CMD_W),
      .DEPTH(FIFO_DEPTH)
   ) u_cmd_fifo (
      .pclk(pclk),
      .presetn(presetn),
      .in_valid(port_valid),
      .in_ready(fifo_in_ready),
      .in_data(fifo_in_data),
      .out_valid(fifo_out_valid),
      .out_ready(fifo_out_ready),
      .out_data(fifo_out_data)
   );

   // APB address decode
   logic [7:0] reg_idx;
   logic reg_hit;
   logic [31:0] reg_rdata;

   always_comb begin
      reg_idx = paddr[PFC_PADDR_W-1:2];
      reg_hit = (paddr[1:0] == 2'h0);
      reg_rdata = 32'h0000_0000;
      case (reg_idx)
         PFC_IDX_MASK0: reg_rdata[7:0] = s_r.mask[7:0];
         PFC_IDX_MASK1: reg_rdata[7:0] = s_r.mask[15:8];
         PFC_IDX_MASK2: reg_rdata[7:0] = s_r.mask[23:16];
         PFC_IDX_MASK3: reg_rdata[3:0] = s_r.mask[27:24];
         PFC_IDX_BASE0: reg_rdata[7:0] = s_r.target_base_address[7:0];
         PFC_IDX_BASE1: reg_rdata[7:0] = s_r.target_base_address[15:8];
         PFC_IDX_BASE2: reg_rdata[7:0] = s_r.target_base_address[23:16];
         PFC_IDX_BASE3: reg_rdata[7:0] = s_r.target_base_address[31:24];
         PFC_IDX_MODE: reg_rdata[3:0] = s_r.mode;
         PFC_IDX_ARR: reg_rdata[1:0] = s_r.arr;
         PFC_IDX_STATUS: reg_rdata[1:0] = {fifo_in_ready, s_r.cmd_valid | fifo_out_valid};
         default: reg_hit = 1'b0;
      endcase
   end

   always_comb begin
      s_nxt = s_r;
      s_nxt.pready = 1'b0;
      s_nxt.pslverr = 1'b0;
      case (s_r.ast)
         PFC_APB_IDLE: begin
            // No wait states: answer is ready in the first access cycle
            if (psel && !penable) begin
               s_nxt.ast = PFC_APB_DONE;
               s_nxt.pready = 1'b1;
               s_nxt.pslverr = ~reg_hit;
               s_nxt.prdata = (reg_hit && !pwrite) ? reg_rdata : 32'h0000_0000;
            end
         end
         PFC_APB_DONE: begin
            s_nxt.ast = PFC_APB_IDLE;
            if (psel && penable && pwrite && reg_hit && pstrb[0]) begin
               case (reg_idx)
                  PFC_IDX_MASK0: s_nxt.mask[7:0] = pwdata[7:0];
                  PFC_IDX_MASK1: s_nxt.mask[15:8] = pwdata[7:0];
                  PFC_IDX_MASK2: s_nxt.mask[23:16] = pwdata[7:0];
                  PFC_IDX_MASK3: s_nxt.mask[27:24] = pwdata[3:0];
                  PFC_IDX_BASE0: s_nxt.target_base_address[7:0] = pwdata[7:0];
                  PFC_IDX_BASE1: s_nxt.target_base_address[15:8] = pwdata[7:0];
                  PFC_IDX_BASE2: s_nxt.target_base_address[23:16] = pwdata[7:0];
                  PFC_IDX_BASE3: s_nxt.target_base_address[31:24] = pwdata[7:0];
                  PFC_IDX_MODE: s_nxt.mode = pwdata[3:0];
                  PFC_IDX_ARR: s_nxt.arr = pwdata[1:0];
                  default: s_nxt.mode = s_r.mode;
               endcase
            end
         end
         default: s_nxt.ast = PFC_APB_IDLE;
      endcase

      // Output stage keeps memory signals on flops while the FIFO drains
      if (!s_r.cmd_valid || mem_ready) begin
         s_nxt.cmd_valid = fifo_out_valid;
         if (fifo_out_valid) begin
            {s_nxt.cmd_write, s_nxt.cmd_addr, s_nxt.cmd_wdata, s_nxt.cmd_size} = fifo_out_data;
         end
      end

      // Read data uses the mode at return time, so keep it stable during traffic
      s_nxt.rvalid = mem_rvalid;
      if (mem_rvalid) begin
         // Without a conversion mode the word is passed as stored, like writes
         s_nxt.rdata = mem_rdata;
         if (is_fmt8(s_r.mode) || is_fmt16(s_r.mode)) begin
            s_nxt.rdata = from_argb(expand(mem_rdata, s_r.mode), s_r.arr);
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_r <= '0;
         s_r.target_base_address <= PFC_BASE_RST;
         s_r.mask <= PFC_MASK_RST;
         s_r.mode <= PFC_MODE_RST;
         s_r.arr <= PFC_ARR_RST;
         s_r.ast <= PFC_APB_IDLE;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign prdata = s_r.prdata;
   assign pready = s_r.pready;
   assign pslverr = s_r.pslverr;
   assign port_ready = fifo_in_ready;
   assign port_rvalid = s_r.rvalid;
   assign port_rdata = s_r.rdata;
   assign mem_valid = s_r.cmd_valid;
   assign mem_write = s_r.cmd_write;
   assign mem_addr = s_r.cmd_addr;
   assign mem_wdata = s_r.cmd_wdata;
   assign mem_size = s_r.cmd_size;
endmodule

`default_nettype wire

// ---- testbench/pfc_converter_sva.sv ----
/* Port checker for the pixel format port converter.
 Sees only the converter ports; bound from the bench top file. */
`timescale 1ns/1ps
`default_nettype none
module pfc_converter_sva
   import pfc_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [PFC_PADDR_W-1:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic mem_valid,
   input wire logic mem_ready,
   input wire logic mem_write,
   input wire logic [31:0] mem_addr,
   input wire logic [31:0] mem_wdata,
   input wire logic [1:0] mem_size,
   input wire logic mem_rvalid,
   input wire logic port_rvalid
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_access;
      psel && penable && pready;
   endsequence
   property p_apb_answer;
      s_setup |=> s_access;
   endproperty
   a_apb_answer: assert property (p_apb_answer)
      else $error("no answer after setup");
   property p_ready_pulse;
      pready |=> !pready;
   endproperty
   a_ready_pulse: assert property (p_ready_pulse)
      else $error("pready longer than one cycle");
   property p_ready_cause;
      pready |-> psel && penable && $past(psel && !penable);
   endproperty
   a_ready_cause: assert property (p_ready_cause)
      else $error("pready without access phase");
   property p_misalign_err;
      s_setup and paddr[1:0] != 2'h0 |=> pslverr && prdata == 32'h0;
   endproperty
   a_misalign_err: assert property (p_misalign_err)
      else $error("misaligned access not refused");
   property p_upper_zero;
      pready && !pwrite && !pslverr |-> prdata[31:8] == 24'h0;
   endproperty
   a_upper_zero: assert property (p_upper_zero)
      else $error("upper read bits not zero");
   property p_mem_hold;
      mem_valid && !mem_ready |=> mem_valid && $stable(mem_addr) && $stable(mem_wdata)
         && $stable(mem_size) && $stable(mem_write);
   endproperty
   a_mem_hold: assert property (p_mem_hold)
      else $error("memory request changed while stalled");
   property p_rvalid_follow;
      mem_rvalid |=> port_rvalid;
   endproperty
   a_rvalid_follow: assert property (p_rvalid_follow)
      else $error("read data not returned");
   property p_rvalid_cause;
      port_rvalid |-> $past(mem_rvalid);
   endproperty
   a_rvalid_cause: assert property (p_rvalid_cause)
      else $error("read data without memory answer");
   property p_size_legal;
      mem_valid |-> mem_size != 2'h3;
   endproperty
   a_size_legal: assert property (p_size_legal)
      else $error("illegal transfer size");
endmodule
`default_nettype wire

// ---- testbench/pfc_mem_model.sv ----
/* Memory partner: accepts requests with a periodic stall, none while hold
 is high, and answers reads in order with an address-derived pattern. */
`timescale 1ns/1ps
`default_nettype none
module pfc_mem_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic hold,
   input wire logic mem_valid,
   output logic mem_ready,
   input wire logic mem_write,
   input wire logic [31:0] mem_addr,
   output logic mem_rvalid,
   output logic [31:0] mem_rdata
);
   logic [31:0] pend[$];
   logic [3:0] cnt;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt <= 4'h0;
         mem_ready <= 1'b0;
         mem_rvalid <= 1'b0;
         mem_rdata <= 32'h0;
         pend.delete();
      end else begin
         cnt <= cnt + 4'h1;
         // Stall one cycle in four so held requests get exercised
         mem_ready <= !hold && cnt[1:0] != 2'h3;
         if (pend.size() > 0 && cnt[0]) begin
            mem_rvalid <= 1'b1;
            mem_rdata <= {~pend[0][15:0], pend[0][31:16]} ^ 32'h3C5A_96E1;
            void'(pend.pop_front());
         end else begin
            mem_rvalid <= 1'b0;
            // No stale value on an idle data bus
            mem_rdata <= ~mem_rdata;
         end
         if (mem_valid && mem_ready && !mem_write)
            pend.push_back(mem_addr);
      end
   end
endmodule
`default_nettype wire

// ---- testbench/test_pixel_format_port_converter.sv ----
/* Self-checking bench for the pixel format port converter.
 Drives APB and the converter port, memory side from pfc_mem_model. */
`timescale 1ns/1ps
`default_nettype none
module test_pixel_format_port_converter import pfc_pkg::*;;
   logic pclk, presetn, psel, penable, pwrite, port_valid, port_ready, port_write, hold;
   logic pready, pslverr, port_rvalid, mem_valid, mem_ready, mem_write, mem_rvalid, er;
   logic [PFC_PADDR_W-1:0] paddr;
   logic [3:0] pstrb, cur_mode;
   logic [1:0] cur_arr, mem_size;
   logic [31:0] pwdata, prdata, port_addr, port_wdata, port_rdata, mem_addr, mem_wdata;
   logic [31:0] mem_rdata, mask, base, a, d, v, rd;
   logic [66:0] mq[$];
   logic [31:0] rq[$];
   logic [3:0] modes[8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h5, 4'h6, 4'h7, 4'hA};
   int err_total, checks, seed, cycles;
   pfc_converter #(.FIFO_DEPTH(4)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .port_valid(port_valid),
      .port_ready(port_ready), .port_write(port_write), .port_addr(port_addr),
      .port_wdata(port_wdata), .port_rvalid(port_rvalid), .port_rdata(port_rdata),
      .mem_valid(mem_valid), .mem_ready(mem_ready), .mem_write(mem_write),
      .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_size(mem_size),
      .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata));
   pfc_mem_model u_mem (.pclk(pclk), .presetn(presetn), .hold(hold),
      .mem_valid(mem_valid), .mem_ready(mem_ready), .mem_write(mem_write),
      .mem_addr(mem_addr), .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata));
   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   task automatic chk(input logic [66:0] got, input logic [66:0] exp);
      checks++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic end_sim();
      if (err_total == 0 && checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [7:0] idx, input logic [1:0] lo,
      input logic [31:0] wd);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {idx, lo};
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic set4(input logic [7:0] idx, input logic [31:0] val);
      for (int i = 0; i < 4; i++) apb(1'b1, idx + i[7:0], 2'h0, {24'h0, val[8*i+:8]});
   endtask
   task automatic port(input logic w, input logic [31:0] pa, input logic [31:0] pd);
      @(posedge pclk);
      port_valid <= 1'b1;
      port_write <= w;
      port_addr <= pa;
      port_wdata <= pd;
      do @(posedge pclk); while (port_ready !== 1'b1);
      port_valid <= 1'b0;
   endtask
   task automatic drain();
      for (int i = 0; i < 200 && (mq.size() > 0 || rq.size() > 0); i++) @(posedge pclk);
      repeat (8) @(posedge pclk);
   endtask
   function automatic logic [1:0] sz(input logic [3:0] m);
      case (m)
         4'h1, 4'h3, 4'h5, 4'h7: return PFC_SIZE_BYTE;
         4'h2, 4'h6, 4'hA: return PFC_SIZE_HALF;
         default: return PFC_SIZE_WORD;
      endcase
   endfunction
   function automatic logic [31:0] msk(input logic [1:0] s);
      return s == PFC_SIZE_BYTE ? 32'hFF : s == PFC_SIZE_HALF ? 32'hFFFF : 32'hFFFF_FFFF;
   endfunction
   // Between ARGB channel order and the selected word arrangement
   function automatic logic [31:0] arrange(input logic [31:0] c, input logic inv);
      case (cur_arr)
         2'h1: return inv ? {c[7:0], c[31:8]} : {c[23:0], c[31:24]};
         2'h2: return {c[31:24], c[7:0], c[15:8], c[23:16]};
         2'h3: return {c[7:0], c[15:8], c[23:16], c[31:24]};
         default: return c;
      endcase
   endfunction
   function automatic logic [66:0] mexp(input logic w, input logic [31:0] pa,
      input logic [31:0] pd);
      logic [27:0] off;
      logic [31:0] c, p;
      logic [1:0] s;
      s = sz(cur_mode);
      off = pa[27:0] & ~mask[27:0];
      off = s == PFC_SIZE_BYTE ? {2'h0, off[27:2]} : s == PFC_SIZE_HALF ? {1'h0, off[27:1]} : off;
      c = arrange(pd, 1'b1);
      p = cur_mode == PFC_MODE_RGB332 ? {24'h0, c[23:21], c[15:13], c[7:6]} :
         cur_mode == PFC_MODE_RGB565 ? {16'h0, c[23:19], c[15:10], c[7:3]} : pd;
      return {w, base + {4'h0, off}, s, w ? p & msk(s) : 32'h0};
   endfunction
   function automatic logic [31:0] rexp(input logic [31:0] x);
      logic [31:0] c;
      case (cur_mode)
         PFC_MODE_RGB332: c = {PFC_ALPHA_OPAQUE, {2{x[7:5]}}, x[7:6], {2{x[4:2]}}, x[4:3],
            {4{x[1:0]}}};
         PFC_MODE_RGB565: c = {PFC_ALPHA_OPAQUE, x[15:11], x[15:13], x[10:5], x[10:9], x[4:0],
            x[4:2]};
         PFC_MODE_LUMINANCE_BYTE: c = {PFC_ALPHA_OPAQUE, {3{x[7:0]}}};
         PFC_MODE_ALPHA_BYTE: c = {x[7:0], 24'h0};
         PFC_MODE_RGBA4444: c = {{2{x[3:0]}}, {2{x[15:12]}}, {2{x[11:8]}}, {2{x[7:4]}}};
         PFC_MODE_LUM4A4: c = {{2{x[3:0]}}, {6{x[7:4]}}};
         PFC_MODE_LUM8A8: c = {x[7:0], {3{x[15:8]}}};
         default: return x;
      endcase
      return arrange(c, 1'b0);
   endfunction
   always @(posedge pclk) begin
      if (presetn && mem_valid === 1'b1 && mem_ready)
         chk({mem_write, mem_addr, mem_size, mem_write ? mem_wdata & msk(mem_size) : 32'h0},
            mq.pop_front());
      if (mem_rvalid)
         rq.push_back(rexp(mem_rdata));
      if (port_rvalid === 1'b1)
         chk(port_rdata, rq.pop_front());
   end
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 20000) begin
         err_total++;
         end_sim();
      end
   end
   initial begin
      {seed, err_total, checks, cycles} = {32'd82803, 96'h0};
      {psel, penable, pwrite, port_valid, port_write, hold, presetn} = 7'h0;
      {paddr, pwdata, port_addr, port_wdata, mask, base} = '0;
      pstrb = 4'hF;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 6; i++) begin
         apb(1'b0, PFC_IDX_BASE0 + i[7:0], 2'h0, 32'h0);
         chk({er, rd}, 33'h0);
      end
      for (int i = 0; i < 4; i++) begin
         v = $random(seed);
         apb(1'b1, PFC_IDX_BASE0 + i[7:0], 2'h0, v);
         apb(1'b0, PFC_IDX_BASE0 + i[7:0], 2'h0, 32'h0);
         chk({er, rd}, {25'h0, v[7:0]});
      end
      apb(1'b0, 8'h00, 2'h0, 32'h0);
      chk(er, 1'b1);
      apb(1'b1, PFC_IDX_BASE0, 2'h1, 32'hFF);
      chk(er, 1'b1);
      foreach (modes[k]) for (int ar = 0; ar < 4; ar++) begin
         cur_mode = modes[k];
         cur_arr = ar[1:0];
         mask = $random(seed) & 32'h0F00_F00F;
         v = $random(seed);
         base = v & ~((32'h1 << sz(cur_mode)) - 32'h1);
         set4(PFC_IDX_MASK0, mask);
         set4(PFC_IDX_BASE0, base);
         apb(1'b1, PFC_IDX_MODE, 2'h0, {28'h0, cur_mode});
         apb(1'b1, PFC_IDX_ARR, 2'h0, {30'h0, cur_arr});
         repeat (2) begin
            a = ar == 3 ? 32'hFFFF_FFFF : $random(seed);
            d = $random(seed);
            mq.push_back(mexp(1'b1, a, d));
            port(1'b1, a, d);
            a = $random(seed);
            mq.push_back(mexp(1'b0, a, 32'h0));
            port(1'b0, a, 32'h0);
         end
         drain();
      end
      hold <= 1'b1;
      for (int i = 0; i < 8 && port_ready === 1'b1; i++) begin
         {a, d} = {$random(seed), $random(seed)};
         mq.push_back(mexp(1'b1, a, d));
         port(1'b1, a, d);
         @(posedge pclk);
      end
      chk(port_ready, 1'b0);
      hold <= 1'b0;
      drain();
      apb(1'b0, PFC_IDX_STATUS, 2'h0, 32'h0);
      chk(rd, 32'h2);
      end_sim();
   end
endmodule
bind pfc_converter pfc_converter_sva u_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .mem_valid(mem_valid), .mem_ready(mem_ready), .mem_write(mem_write),
   .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_size(mem_size),
   .mem_rvalid(mem_rvalid), .port_rvalid(port_rvalid));
`default_nettype wire
